/* inc/fhp_consts.svh */
// Purpose: Offsets, field positions, reset values of the readback bank
// Assumes: 7-bit register addresses, 24-bit register payloads
// Notes: Header payload is kept as its upper 24 bits
`ifndef FHP_CONSTS_SVH
`define FHP_CONSTS_SVH

`define FHP_ADDR_AMP0 7'h31
`define FHP_ADDR_AMP1 7'h32
`define FHP_ADDR_AMP2 7'h33
`define FHP_ADDR_P1 7'h3a
`define FHP_ADDR_P2 7'h3b
`define FHP_ADDR_P3 7'h3c
`define FHP_ADDR_HDR 7'h40
`define FHP_ADDR_CRC 7'h41

`define FHP_HDR_RST 24'h800000
`define FHP_CRC_RST 24'hffffff
`define FHP_AMP_RST 16'h0000
`define FHP_PACE_RST 24'h000000

`define FHP_B_MARK 31
`define FHP_B_READY 30
`define FHP_B_MISS_HI 29
`define FHP_B_MISS_LO 28
`define FHP_B_FAULT 27
`define FHP_B_PACE_LO 24
`define FHP_B_RESP 23
`define FHP_B_LOFF 22
`define FHP_B_DCOFF 21
`define FHP_B_OOR 20

`define FHP_WIDTH_MIN 8'h0c
`define FHP_MISS_MAX 2'h3
`define FHP_MISS_FLAG 2'h1

`endif

/* inc/fhp_pkg.sv */
// Purpose: Types shared by the readback bank
// Assumes: Nothing beyond the constants header
// Notes: Output data rate selection
package fhp_pkg;
  typedef enum logic [1:0] {
    fhp_rate_2k = 2'b00,
    fhp_rate_16k = 2'b01,
    fhp_rate_128k = 2'b10
  } fhp_rate_e;
endpackage

/* rtl/fhp_frame_readback.sv */
// Purpose: Frame header, pace, ac electrode-off and check word readback
// Assumes: All inputs come from logic on clk_sys_i
// Notes: Read answer is registered, one cycle after rd_en_i
// Function
// - Pace height signed, bits 23:8
// - Pace width count N in bits 7:0
// - Width filter on: width never below 12
// - Pace results only by register read
// - Header bit 31 always one
// - Header bit 30: zero ready, one busy
// - Bits 29:28 count missed frames, saturate; skip mode only raises 01 from zero
// - Bit 27 flags internal device error
// - Bits 26:24 pace instances three to one
// - Bit 23 new respiration data
// - Bit 22 ac electrode-off OR when ac and dc both enabled, else OR of ac and dc
// - Bit 21 dc electrode-off detected
// - Bit 20 converter out of range
// - Header at 0x40, reset 0x800000
// - 128 kHz frame mode: header upper 16
// - Check word 0x41, reset 0xffffff, sized
// - Amplitude registers 0x31-0x33, register read only
// - Amplitude unsigned 16 bits, 8 Hz updates
`include "fhp_consts.svh"
module fhp_frame_readback (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic rd_en_i,
  input wire logic [6:0] rd_addr_i,
  input wire logic frame_mode_i,
  input wire fhp_pkg::fhp_rate_e rate_i,
  input wire logic skip_mode_i,
  input wire logic busy_i,
  input wire logic fault_i,
  input wire logic frame_done_i,
  input wire logic resp_upd_i,
  input wire logic ac_en_i,
  input wire logic dc_en_i,
  input wire logic [2:0] ac_off_i,
  input wire logic [2:0] dc_off_i,
  input wire logic adc_oor_i,
  input wire logic [2:0] pace_qual_i,
  input wire logic pace_wfilt_en_i,
  input wire logic [47:0] pace_height_i,
  input wire logic [23:0] pace_width_i,
  input wire logic [2:0] amp_upd_i,
  input wire logic [47:0] amp_val_i,
  input wire logic crc_load_i,
  input wire logic [23:0] crc_val_i,
  output logic rd_valid_o,
  output logic [31:0] rd_data_o,
  output logic rd_short_o,
  output logic rd_refused_o
);
  logic [1:0] miss_reg;
  logic [1:0] miss_next;
  logic pend_reg;
  logic pend_next;
  logic [2:0] pace_flag_reg;
  logic [2:0] pace_flag_next;
  logic [2:0] pace_acc_reg;
  logic [2:0] pace_acc_next;
  logic resp_reg;
  logic resp_next;
  logic [4:0] stat_reg;
  logic [4:0] stat_next;
  logic [23:0] crc_reg;
  logic [23:0] crc_next;
  logic [47:0] amp_reg;
  logic [47:0] amp_next;
  logic [71:0] pace_res;
  logic rd_valid_reg;
  logic rd_valid_next;
  logic [31:0] rd_data_reg;
  logic [31:0] rd_data_next;
  logic rd_short_reg;
  logic rd_short_next;
  logic rd_ref_reg;
  logic rd_ref_next;
  logic hdr_rd;
  logic fast;
  logic loff;
  logic [31:0] hdr_word;

  // Status order: busy, fault, lead-off, dc lead-off, out of range
  assign hdr_rd = rd_en_i && frame_mode_i && (rd_addr_i == `FHP_ADDR_HDR);
  assign fast = (rate_i == fhp_pkg::fhp_rate_128k);

  // Pace result slots and amplitude register next values
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pace
      fhp_pace_slot u_slot (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .qual_i(pace_qual_i[gi]),
        .wfilt_en_i(pace_wfilt_en_i),
        .height_i(pace_height_i[16*gi +: 16]),
        .width_i(pace_width_i[8*gi +: 8]),
        .result_o(pace_res[24*gi +: 24])
      );
    end
    for (gi = 0; gi < 3; gi++) begin : g_amp
      always_comb begin
        amp_next[16*gi +: 16] = amp_reg[16*gi +: 16];
        if (amp_upd_i[gi]) begin
          amp_next[16*gi +: 16] = amp_val_i[16*gi +: 16];
        end
      end
    end
  endgenerate

  always_comb begin
    if (ac_en_i && dc_en_i) begin
      loff = |ac_off_i;
    end else begin
      loff = |(ac_off_i | dc_off_i);
    end
  end

  // Header and check word state
  always_comb begin
    miss_next = miss_reg;
    pend_next = pend_reg;
    if (hdr_rd) begin
      miss_next = 2'h0;
      pend_next = 1'b0;
    end
    if (frame_done_i) begin
      pend_next = 1'b1;
      if (pend_reg && !hdr_rd) begin
        if (skip_mode_i) begin
          if (miss_reg == 2'h0) begin
            miss_next = `FHP_MISS_FLAG;
          end
        end else if (miss_reg != `FHP_MISS_MAX) begin
          miss_next = miss_reg + 2'h1;
        end
      end
    end
    pace_acc_next = pace_acc_reg | pace_qual_i;
    pace_flag_next = pace_flag_reg;
    if (frame_done_i) begin
      pace_flag_next = pace_acc_reg | pace_qual_i;
      pace_acc_next = 3'h0;
    end
    // New update wins over a same-cycle read
    resp_next = (resp_reg && !hdr_rd) || resp_upd_i;
    stat_next = {busy_i, fault_i, loff, |dc_off_i, adc_oor_i};
    crc_next = crc_load_i ? crc_val_i : crc_reg;
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      miss_reg <= 2'h0;
      pend_reg <= 1'b0;
      pace_flag_reg <= 3'h0;
      pace_acc_reg <= 3'h0;
      resp_reg <= 1'b0;
      stat_reg <= 5'h00;
      crc_reg <= `FHP_CRC_RST;
      amp_reg <= {3{`FHP_AMP_RST}};
    end else begin
      miss_reg <= miss_next;
      pend_reg <= pend_next;
      pace_flag_reg <= pace_flag_next;
      pace_acc_reg <= pace_acc_next;
      resp_reg <= resp_next;
      stat_reg <= stat_next;
      crc_reg <= crc_next;
      amp_reg <= amp_next;
    end
  end

  always_comb begin
    hdr_word = {`FHP_HDR_RST, 8'h00};
    hdr_word[`FHP_B_MARK] = 1'b1;
    hdr_word[`FHP_B_READY] = stat_reg[4];
    hdr_word[`FHP_B_MISS_HI:`FHP_B_MISS_LO] = miss_reg;
    hdr_word[`FHP_B_FAULT] = stat_reg[3];
    hdr_word[`FHP_B_PACE_LO +: 3] = pace_flag_reg;
    hdr_word[`FHP_B_RESP] = resp_reg;
    hdr_word[`FHP_B_LOFF] = stat_reg[2];
    hdr_word[`FHP_B_DCOFF] = stat_reg[1];
    hdr_word[`FHP_B_OOR] = stat_reg[0];
  end

  // Read answer
  always_comb begin
    rd_valid_next = rd_en_i;
    rd_short_next = 1'b0;
    rd_ref_next = 1'b0;
    rd_data_next = {1'b0, rd_addr_i, 24'h000000};
    if (rd_en_i) begin
      case (rd_addr_i)
        `FHP_ADDR_AMP0, `FHP_ADDR_AMP1, `FHP_ADDR_AMP2: begin
          if (frame_mode_i) begin
            rd_ref_next = 1'b1;
            rd_data_next = 32'h00000000;
          end else begin
            rd_data_next[15:0] =
              amp_reg[16*(rd_addr_i - `FHP_ADDR_AMP0) +: 16];
          end
        end
        `FHP_ADDR_P1, `FHP_ADDR_P2, `FHP_ADDR_P3: begin
          if (frame_mode_i) begin
            rd_ref_next = 1'b1;
            rd_data_next = 32'h00000000;
          end else begin
            rd_data_next[23:0] =
              pace_res[24*(rd_addr_i - `FHP_ADDR_P1) +: 24];
          end
        end
        `FHP_ADDR_HDR: begin
          if (frame_mode_i && fast) begin
            rd_short_next = 1'b1;
            rd_data_next = {16'h0000, hdr_word[31:16]};
          end else begin
            rd_data_next = hdr_word;
          end
        end
        `FHP_ADDR_CRC: begin
          if (fast) begin
            rd_short_next = 1'b1;
            rd_data_next = {16'h0000, crc_reg[15:0]};
          end else begin
            rd_data_next[23:0] = crc_reg;
          end
        end
        default: begin
          rd_data_next = {1'b0, rd_addr_i, 24'h000000};
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rd_valid_reg <= 1'b0;
      rd_data_reg <= 32'h00000000;
      rd_short_reg <= 1'b0;
      rd_ref_reg <= 1'b0;
    end else begin
      rd_valid_reg <= rd_valid_next;
      rd_data_reg <= rd_data_next;
      rd_short_reg <= rd_short_next;
      rd_ref_reg <= rd_ref_next;
    end
  end

  assign rd_valid_o = rd_valid_reg;
  assign rd_data_o = rd_data_reg;
  assign rd_short_o = rd_short_reg;
  assign rd_refused_o = rd_ref_reg;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  property p_marker;
    rd_en_i && (rd_addr_i == `FHP_ADDR_HDR) && !(frame_mode_i && fast)
      |=> rd_data_o[31] && (rd_data_o[19:0] == 20'h00000);
  endproperty
  a_marker: assert property (p_marker)
    else $error("header marker or reserved bits wrong");

  property p_ready;
    busy_i ##1 rd_en_i && (rd_addr_i == `FHP_ADDR_HDR) && !fast
      |=> rd_data_o[30];
  endproperty
  a_ready: assert property (p_ready)
    else $error("busy not shown in header");

  property p_pace_refused;
    rd_en_i && frame_mode_i && (rd_addr_i >= `FHP_ADDR_P1)
      && (rd_addr_i <= `FHP_ADDR_P3)
      |=> rd_refused_o && (rd_data_o == 32'h00000000);
  endproperty
  a_pace_refused: assert property (p_pace_refused)
    else $error("pace result leaked into frame");

  property p_amp_refused;
    rd_en_i && frame_mode_i && (rd_addr_i >= `FHP_ADDR_AMP0)
      && (rd_addr_i <= `FHP_ADDR_AMP2) |=> rd_refused_o;
  endproperty
  a_amp_refused: assert property (p_amp_refused)
    else $error("amplitude leaked into frame");

  property p_miss_count;
    frame_done_i && pend_reg && !hdr_rd && !skip_mode_i
      && (miss_reg != `FHP_MISS_MAX)
      |=> miss_reg == $past(miss_reg) + 2'h1;
  endproperty
  a_miss_count: assert property (p_miss_count)
    else $error("missed frame count did not advance");

  property p_miss_sat;
    (miss_reg == `FHP_MISS_MAX) && !hdr_rd |=> miss_reg == `FHP_MISS_MAX;
  endproperty
  a_miss_sat: assert property (p_miss_sat)
    else $error("missed frame count did not saturate");

  property p_skip;
    skip_mode_i && frame_done_i && pend_reg && !hdr_rd
      |=> miss_reg != 2'h0;
  endproperty
  a_skip: assert property (p_skip)
    else $error("skip overflow flag not raised");

  property p_loff;
    ac_en_i && dc_en_i ##1 rd_en_i && (rd_addr_i == `FHP_ADDR_HDR) && !fast
      |=> rd_data_o[22] == $past(|ac_off_i, 2);
  endproperty
  a_loff: assert property (p_loff)
    else $error("electrode-off summary wrong");

  property p_resp;
    resp_upd_i |=> resp_reg;
  endproperty
  a_resp: assert property (p_resp)
    else $error("respiration update lost");

  property p_hdr16;
    rd_en_i && (rd_addr_i == `FHP_ADDR_HDR) && frame_mode_i && fast
      |=> rd_short_o && rd_data_o[15] && (rd_data_o[31:16] == 16'h0000);
  endproperty
  a_hdr16: assert property (p_hdr16)
    else $error("short header form wrong");

  property p_crc16;
    rd_en_i && (rd_addr_i == `FHP_ADDR_CRC) && fast
      |=> rd_short_o && (rd_data_o[15:0] == $past(crc_reg[15:0]));
  endproperty
  a_crc16: assert property (p_crc16)
    else $error("short check word wrong");

  c_miss_sat: cover property (miss_reg == `FHP_MISS_MAX);
  c_pace_read: cover property (rd_en_i && !frame_mode_i
    && (rd_addr_i == `FHP_ADDR_P2));
  c_hdr_short: cover property (rd_valid_o && rd_short_o);
endmodule

/* rtl/fhp_pace_slot.sv */
// Purpose: One pace width and height result register
// Assumes: qual_i is a one-cycle pulse with height and width valid
// Notes: Holds last result until the next qualified artifact
`include "fhp_consts.svh"
module fhp_pace_slot (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic qual_i,
  input wire logic wfilt_en_i,
  input wire logic [15:0] height_i,
  input wire logic [7:0] width_i,
  output logic [23:0] result_o
);
  logic [23:0] result_reg;
  logic [23:0] result_next;
  logic [7:0] width_eff;

  always_comb begin
    width_eff = width_i;
    if (wfilt_en_i && (width_i < `FHP_WIDTH_MIN)) begin
      width_eff = `FHP_WIDTH_MIN;
    end
    result_next = result_reg;
    if (qual_i) begin
      result_next = {height_i, width_eff};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      result_reg <= `FHP_PACE_RST;
    end else begin
      result_reg <= result_next;
    end
  end

  assign result_o = result_reg;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  property p_width_min;
    qual_i && wfilt_en_i |=> result_reg[7:0] >= `FHP_WIDTH_MIN;
  endproperty
  a_width_min: assert property (p_width_min)
    else $error("pace width below minimum with filter on");

  property p_height;
    qual_i |=> result_reg[23:8] == $past(height_i);
  endproperty
  a_height: assert property (p_height)
    else $error("pace height not captured");

  property p_width_raw;
    qual_i && !wfilt_en_i |=> result_reg[7:0] == $past(width_i);
  endproperty
  a_width_raw: assert property (p_width_raw)
    else $error("pace width not captured unfiltered");

  property p_hold;
    !qual_i |=> $stable(result_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("pace result changed without qualification");
endmodule

/* verif/fhp_host_model.sv */
// Purpose: Host reading words from the readback bank
// Assumes: Called just after a rising edge of clk_sys_i
// Notes: Address goes to its inverse once a read is taken
module fhp_host_model (
  input wire logic clk_sys_i,
  input wire logic rd_valid_i,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_short_i,
  input wire logic rd_refused_i,
  output logic rd_en_o,
  output logic [6:0] rd_addr_o,
  output logic frame_mode_o,
  output logic stale_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    rd_en_o = 1'b0;
    rd_addr_o = 7'h00;
    frame_mode_o = 1'b0;
    stale_o = 1'b0;
  end
  task automatic xfer(input logic [6:0] a, input logic f,
                      output logic [31:0] d, output logic [2:0] vsr);
    rd_en_o = 1'b1;
    rd_addr_o = a;
    frame_mode_o = f;
    @(posedge clk_sys_i);
    #1;
    // Answer stands for the cycle after the request edge
    d = rd_data_i;
    vsr = {rd_valid_i, rd_short_i, rd_refused_i};
    // Frame kept but marked old when read bits 29:28 show missed frames
    stale_o = f && a == 7'h40 && rd_data_i[29:28] != 2'h0;
    rd_en_o = 1'b0;
    rd_addr_o = ~a;
    @(posedge clk_sys_i);
    #1;
  endtask
endmodule

/* verif/frame_header_pace_readback_tb.sv */
// Purpose: Self-checking bench for the readback bank
// Assumes: Fixed one-cycle read answer
// Notes: Inputs change 1 ns after the rising edge
module frame_header_pace_readback_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0, reset = 1'b1, skip = 1'b0, busy = 1'b0;
  logic fault = 1'b0, fdone = 1'b0, resp = 1'b0, ac_en = 1'b0;
  logic dc_en = 1'b0, oor = 1'b0, wfilt = 1'b0, crc_ld = 1'b0;
  logic [2:0] ac_off = 3'h0, dc_off = 3'h0, qual = 3'h0;
  logic [2:0] amp_upd = 3'h0;
  logic [47:0] height = 48'h0, amp_val = 48'h0;
  logic [23:0] width = 24'h0, crc_val = 24'h0;
  fhp_pkg::fhp_rate_e rate = fhp_pkg::fhp_rate_2k;
  logic rd_en, frame_mode, rd_valid, rd_short, rd_refused, stale;
  logic [6:0] rd_addr;
  logic [31:0] rd_data;
  int miscompares = 0, num_checks = 0;
  logic [6:0] addrs [8] = '{7'h31, 7'h32, 7'h33, 7'h3a, 7'h3b, 7'h3c,
                            7'h40, 7'h41};
  logic [31:0] rst_w [8] = '{32'h31000000, 32'h32000000, 32'h33000000,
    32'h3a000000, 32'h3b000000, 32'h3c000000, 32'h80000000, 32'h41ffffff};

  fhp_frame_readback dut_u (.clk_sys_i(clk_sys), .reset_i(reset),
    .rd_en_i(rd_en), .rd_addr_i(rd_addr), .frame_mode_i(frame_mode),
    .rate_i(rate), .skip_mode_i(skip), .busy_i(busy), .fault_i(fault),
    .frame_done_i(fdone), .resp_upd_i(resp), .ac_en_i(ac_en),
    .dc_en_i(dc_en), .ac_off_i(ac_off), .dc_off_i(dc_off),
    .adc_oor_i(oor), .pace_qual_i(qual), .pace_wfilt_en_i(wfilt),
    .pace_height_i(height), .pace_width_i(width), .amp_upd_i(amp_upd),
    .amp_val_i(amp_val), .crc_load_i(crc_ld), .crc_val_i(crc_val),
    .rd_valid_o(rd_valid), .rd_data_o(rd_data), .rd_short_o(rd_short),
    .rd_refused_o(rd_refused));

  fhp_host_model host_u (.clk_sys_i(clk_sys), .rd_valid_i(rd_valid),
    .rd_data_i(rd_data), .rd_short_i(rd_short),
    .rd_refused_i(rd_refused), .rd_en_o(rd_en), .rd_addr_o(rd_addr),
    .frame_mode_o(frame_mode), .stale_o(stale));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic tick(int n = 1);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input logic c, input string m);
    num_checks++;
    if (c !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic rd(input logic [6:0] a, input logic f,
                    input logic [31:0] e, input logic [1:0] sr);
    logic [31:0] d;
    logic [2:0] v;
    host_u.xfer(a, f, d, v);
    chk(d === e && v === {1'b1, sr}, $sformatf("read %h got %h", a, d));
  endtask

  task automatic fd(int n);
    repeat (n) begin
      fdone = 1'b1;
      tick();
      fdone = 1'b0;
      tick();
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    tick(20000);
    miscompares++;
    $display("[ERR] %0t run limit reached", $time);
    complete_run();
  end

  initial begin
    tick(12);
    reset = 1'b0;
    for (int i = 0; i < 8; i++)
      rd(addrs[i], 1'b0, rst_w[i], 2'b00);
    $display("test reset done");
    ac_en = 1'b1;
    dc_en = 1'b1;
    busy = 1'b1;
    fault = 1'b1;
    oor = 1'b1;
    dc_off = 3'h2;
    tick(2);
    rd(7'h40, 1'b0, 32'hc8300000, 2'b00);
    dc_en = 1'b0;
    tick(2);
    rd(7'h40, 1'b0, 32'hc8700000, 2'b00);
    busy = 1'b0;
    fault = 1'b0;
    oor = 1'b0;
    dc_off = 3'h0;
    ac_en = 1'b0;
    tick(2);
    $display("test status done");
    fd(5);
    rd(7'h40, 1'b1, 32'hb0000000, 2'b00);
    chk(stale === 1'b1, "stale flag");
    rd(7'h40, 1'b1, 32'h80000000, 2'b00);
    skip = 1'b1;
    fd(4);
    rd(7'h40, 1'b1, 32'h90000000, 2'b00);
    skip = 1'b0;
    $display("test missed done");
    qual = 3'h4;
    width = 24'hff0000;
    height = 48'h0100_0000_0000;
    wfilt = 1'b1;
    resp = 1'b1;
    tick();
    qual = 3'h0;
    resp = 1'b0;
    fd(1);
    rd(7'h40, 1'b1, 32'h84800000, 2'b00);
    rd(7'h40, 1'b1, 32'h84000000, 2'b00);
    $display("test flags done");
    qual = 3'h1;
    height = 48'h8001;
    width = 24'h05;
    tick();
    qual = 3'h2;
    height = 48'h7fff_0000;
    width = 24'h0500;
    wfilt = 1'b0;
    tick();
    qual = 3'h0;
    rd(7'h3a, 1'b0, 32'h3a80010c, 2'b00);
    rd(7'h3b, 1'b0, 32'h3b7fff05, 2'b00);
    rd(7'h3c, 1'b0, 32'h3c0100ff, 2'b00);
    $display("test pace done");
    amp_upd = 3'h5;
    amp_val = 48'h1234_0000_beef;
    tick();
    amp_upd = 3'h0;
    amp_val = 48'h0;
    rd(7'h31, 1'b0, 32'h3100beef, 2'b00);
    rd(7'h32, 1'b0, 32'h32000000, 2'b00);
    rd(7'h33, 1'b0, 32'h33001234, 2'b00);
    crc_ld = 1'b1;
    crc_val = 24'habcdef;
    tick();
    crc_ld = 1'b0;
    rd(7'h41, 1'b0, 32'h41abcdef, 2'b00);
    rate = fhp_pkg::fhp_rate_16k;
    rd(7'h41, 1'b1, 32'h41abcdef, 2'b00);
    rate = fhp_pkg::fhp_rate_128k;
    rd(7'h41, 1'b0, 32'h0000cdef, 2'b10);
    rd(7'h40, 1'b1, 32'h00008400, 2'b10);
    rd(7'h40, 1'b0, 32'h84000000, 2'b00);
    rate = fhp_pkg::fhp_rate_2k;
    $display("test words done");
    for (int i = 0; i < 6; i++)
      rd(addrs[i], 1'b1, 32'h0, 2'b01);
    rd(7'h50, 1'b0, 32'h50000000, 2'b00);
    $display("test refuse done");
    complete_run();
  end
endmodule
